/* File: inc/fault_pkg.sv */
// Shared constants and types for the sensor fault flag monitor.
// Assumes the surrounding frame logic decodes commands and serialises responses.
package fault_pkg;

    // ==========================================================
    // Register map and bit positions
    // ==========================================================
    localparam logic [8:0] QUAD_LEVEL_ADDR = 9'h008;
    localparam logic [8:0] FAULT_UPPER_ADDR = 9'h00a;
    localparam int UP_FAIL_BIT = 3;
    localparam int UP_SWING_BIT = 2;
    localparam int UP_HIGH_BIT = 1;
    localparam int UP_LOW_BIT = 0;
    localparam int LO_LOCK_BIT = 7;
    localparam int LO_QUAD_BIT = 6;
    localparam int LO_NVM_BIT = 5;
    localparam int LO_VOL_BIT = 4;
    localparam int LO_SUPPLY_BIT = 3;
    localparam int LO_SELF_BIT = 2;
    localparam int LO_INJ_BIT = 1;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    // ==========================================================
    // Thresholds
    // ==========================================================
    localparam logic [15:0] QUAD_LIMIT = 16'h1000;
    localparam logic [15:0] SELF_WARN_LIMIT = 16'h0200;
    localparam logic [15:0] SELF_FAIL_LIMIT = 16'h0740;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ = 50000000;
    localparam int NVM_CHECK_NS = 50000;
    localparam int NVM_CHECK_CYC = NVM_CHECK_NS / (1000000000 / CLK_HZ);
    localparam int VOL_CHECK_NS = 1000;
    localparam int VOL_CHECK_CYC = VOL_CHECK_NS / (1000000000 / CLK_HZ);
    localparam int INJ_SETTLE_MS = 50;
    localparam int INJ_SETTLE_CYC = INJ_SETTLE_MS * (CLK_HZ / 1000);

    // ==========================================================
    // Response type code
    // ==========================================================
    typedef enum logic [1:0] {
        RT_INVALID = 2'b00,
        RT_VALID = 2'b01,
        RT_SELF_TEST = 2'b10,
        RT_READ_WRITE = 2'b11
    } response_type_code_type;

    // Raw fault conditions from the analog monitors; the memory checks run inside the monitor.
    typedef struct packed {
        logic regulator_high;
        logic regulator_low;
        logic swing_low;
        logic lock_lost;
        logic quad_accum_full;
        logic [15:0] self_test_dev;
        logic [15:0] quadrature_level;
    } fault_cond_type;

    // Frame events from the link side.
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic inj_request;
        logic fault_read;
    } frame_evt_type;

endpackage

/* File: logic/event_sync.sv */
// Toggle-based event crossing from a source clock to a destination clock.
// Assumes source events are spaced by several destination cycles.
module event_sync (
    input wire logic src_clk,
    input wire logic dst_clk,
    input wire logic rst,
    input wire logic src_pulse,
    output logic dst_pulse
);

    logic tog_r;
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ==========================================================
    // Source toggle
    // ==========================================================
    // A toggle survives any ratio between the two clocks only while source events are several destination cycles apart.
    always_ff @(posedge src_clk or posedge rst) begin
        if (rst) begin
            tog_r <= 1'b0;
        end else if (src_pulse) begin
            tog_r <= ~tog_r;
        end
    end

    // ==========================================================
    // Destination synchroniser and edge detect
    // ==========================================================
    // Only the second and third stages feed the edge detector.
    always_ff @(posedge dst_clk or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dst_pulse <= 1'b0;
        end else begin
            s1_r <= tog_r;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dst_pulse <= s2_r ^ s3_r;
        end
    end

endmodule

/* File: logic/check_mem.sv */
// Small stored-config memory with a registered read port.
// Assumes the owner walks addresses to compute a checksum.
module check_mem #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    logic [7:0] mem [DEPTH];

    // ==========================================================
    // Storage
    // ==========================================================
    // Content has no reset; the checksum owner compares it from the first pass, so it must be loaded first.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

/* File: logic/fault_monitor.sv */
// Sticky fault flags, response type code and fault injection of the rate sensor.
// Assumes the frame logic on link_clk reports frame start, end, injection and fault reads.
module fault_monitor
    import fault_pkg::*;
#(
    parameter int SETTLE_CYC = INJ_SETTLE_CYC,
    parameter int NVM_DEPTH = 16,
    parameter logic [7:0] NVM_SUM_EXPECTED = 8'h00,
    parameter logic [7:0] ROM_CONSTANT = 8'h5a // Arbitrary pattern.
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire fault_pkg::fault_cond_type cond,
    input wire fault_pkg::frame_evt_type evt,
    input wire logic nvm_wr_en,
    input wire logic [3:0] nvm_wr_addr,
    input wire logic [7:0] nvm_wr_data,
    input wire logic vol_upset,
    output logic [7:0] fault_upper,
    output logic [7:0] fault_lower,
    output logic [15:0] fault_pair,
    output logic [7:0] data_resp_flags,
    output fault_pkg::response_type_code_type response_type_code,
    output logic self_test_drive
);
    import fault_pkg::*;

    localparam int CW = $clog2(SETTLE_CYC + 1);

    logic [7:0] upper_r;
    logic [7:0] lower_r;
    logic [7:0] up_cond;
    logic [7:0] lo_cond;
    logic [7:0] up_hold_r;
    logic [7:0] lo_hold_r;
    logic [$bits(fault_cond_type)-1:0] cond_s1_r;
    logic [$bits(fault_cond_type)-1:0] cond_s2_r;
    fault_cond_type c;
    logic [1:0] inj_s_r;
    logic inj_r;
    logic inj_active_r;
    logic [CW-1:0] settle_r;
    logic start_p;
    logic end_p;
    logic read_p;
    logic read_tog_r;
    logic [2:0] read_s_r;
    logic read_pend_r;
    logic read_clear;
    logic [3:0] nvm_addr_r;
    logic [7:0] nvm_rd;
    logic [7:0] nvm_sum_r;
    logic [15:0] nvm_tmr_r;
    logic nvm_bad;
    logic nvm_bad_r;
    logic [7:0] vol_r;
    logic [5:0] vol_tmr_r;
    logic vol_bad_r;
    logic self_warn;
    logic self_fail;
    logic force_invalid;
    response_type_code_type code_nxt;

    // ==========================================================
    // Crossing of link events and levels
    // ==========================================================
    // The read event is captured as a toggle on the link side.
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            read_tog_r <= 1'b0;
        end else if (evt.frame_end && evt.fault_read) begin
            read_tog_r <= ~read_tog_r;
        end
    end

    event_sync u_start_sync (
        .src_clk(link_clk),
        .dst_clk(sys_clk),
        .rst(rst),
        .src_pulse(evt.frame_start),
        .dst_pulse(start_p)
    );

    event_sync u_end_sync (
        .src_clk(link_clk),
        .dst_clk(sys_clk),
        .rst(rst),
        .src_pulse(evt.frame_end),
        .dst_pulse(end_p)
    );

    // The read toggle crosses on two flops; the third gives its edge, as in the other event crossings.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            read_s_r <= 3'b000;
            read_p <= 1'b0;
        end else begin
            read_s_r <= {read_s_r[1:0], read_tog_r};
            read_p <= read_s_r[1] ^ read_s_r[2];
        end
    end

    // Analog conditions and the injection level arrive asynchronously.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cond_s1_r <= '0;
            cond_s2_r <= '0;
            inj_s_r <= 2'b00;
        end else begin
            cond_s1_r <= cond;
            cond_s2_r <= cond_s1_r;
            inj_s_r <= {inj_s_r[0], evt.inj_request};
        end
    end
    assign c = fault_cond_type'(cond_s2_r);

    // ==========================================================
    // Injection control
    // ==========================================================
    // The request is adopted at a frame start, so its effect shows one exchange late.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inj_r <= 1'b0;
        end else if (start_p) begin
            inj_r <= inj_s_r[1];
        end
    end

    // Injected conditions rise at once and decay over the settle time after release.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_r <= '0;
            inj_active_r <= 1'b0;
        end else if (inj_r) begin
            settle_r <= CW'(SETTLE_CYC);
            inj_active_r <= 1'b1;
        end else if (settle_r != '0) begin
            settle_r <= settle_r - 1'b1;
        end else begin
            inj_active_r <= 1'b0;
        end
    end

    // The self-test drive is pushed past its threshold during injection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            self_test_drive <= 1'b0;
        end else begin
            self_test_drive <= inj_active_r;
        end
    end

    // ==========================================================
    // Stored-config checksum
    // ==========================================================
    check_mem #(
        .DEPTH(NVM_DEPTH),
        .AW(4)
    ) u_nvm (
        .clk(sys_clk),
        .wr_en(nvm_wr_en),
        .wr_addr(nvm_wr_addr),
        .wr_data(nvm_wr_data),
        .rd_addr(nvm_addr_r),
        .rd_data(nvm_rd)
    );

    // Identification bytes are stored elsewhere and are outside this sum.
    assign nvm_bad = (nvm_sum_r + nvm_rd) != NVM_SUM_EXPECTED;

    // Walk the memory each period and compare the sum once per pass.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nvm_tmr_r <= '0;
            nvm_addr_r <= '0;
            nvm_sum_r <= '0;
            nvm_bad_r <= 1'b0;
        end else if (nvm_tmr_r == 16'(NVM_CHECK_CYC - 1)) begin
            nvm_tmr_r <= '0;
            nvm_addr_r <= '0;
            nvm_sum_r <= '0;
        end else begin
            nvm_tmr_r <= nvm_tmr_r + 1'b1;
            if (nvm_tmr_r < 16'(NVM_DEPTH + 1) && nvm_tmr_r != '0) begin
                nvm_sum_r <= nvm_sum_r + nvm_rd;
            end
            if (nvm_addr_r != 4'(NVM_DEPTH - 1)) begin
                nvm_addr_r <= nvm_addr_r + 1'b1;
            end
            if (nvm_tmr_r == 16'(NVM_DEPTH)) begin
                nvm_bad_r <= nvm_bad;
            end
        end
    end

    // ==========================================================
    // Volatile memory integrity
    // ==========================================================
    // The copy is loaded at reset and compared every microsecond.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vol_r <= ROM_CONSTANT;
            vol_tmr_r <= '0;
            vol_bad_r <= 1'b0;
        end else begin
            if (vol_upset) begin
                vol_r <= ~vol_r;
            end
            if (vol_tmr_r == 6'(VOL_CHECK_CYC - 1)) begin
                vol_tmr_r <= '0;
                vol_bad_r <= vol_r != ROM_CONSTANT;
            end else begin
                vol_tmr_r <= vol_tmr_r + 1'b1;
            end
        end
    end

    // ==========================================================
    // Detection criteria
    // ==========================================================
    assign self_warn = c.self_test_dev > SELF_WARN_LIMIT || inj_active_r;
    assign self_fail = c.self_test_dev > SELF_FAIL_LIMIT;
    // A read that clears the lock flag lifts its invalid marking in the same cycle.
    // Otherwise the fail flag would be set again from the flag that is being cleared.
    assign force_invalid = self_fail || c.lock_lost || inj_active_r
        || (lower_r[LO_LOCK_BIT] && !read_clear);

    // Each bit gathers its own criterion; injection drives every one.
    always_comb begin
        up_cond = '0;
        lo_cond = '0;
        up_cond[UP_HIGH_BIT] = c.regulator_high || inj_active_r;
        up_cond[UP_LOW_BIT] = c.regulator_low || inj_active_r;
        up_cond[UP_SWING_BIT] = c.swing_low || inj_active_r;
        up_cond[UP_FAIL_BIT] = force_invalid;
        lo_cond[LO_LOCK_BIT] = c.lock_lost || inj_active_r;
        lo_cond[LO_QUAD_BIT] = c.quadrature_level > QUAD_LIMIT || c.quad_accum_full || inj_active_r;
        lo_cond[LO_NVM_BIT] = nvm_bad_r || inj_active_r;
        lo_cond[LO_VOL_BIT] = vol_bad_r || inj_active_r;
        lo_cond[LO_SUPPLY_BIT] = up_cond[UP_HIGH_BIT] || up_cond[UP_LOW_BIT];
        lo_cond[LO_SELF_BIT] = self_warn;
        lo_cond[LO_INJ_BIT] = inj_r;
    end

    // ==========================================================
    // Sticky flags
    // ==========================================================
    // A read clears only after its frame ends; a live condition wins the clear.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            read_pend_r <= 1'b0;
        end else begin
            read_pend_r <= read_p;
        end
    end
    assign read_clear = read_pend_r;

    // Flags reasserted after a clear are held until the next exchange ends.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upper_r <= FAULT_RESET;
            lower_r <= FAULT_RESET;
            up_hold_r <= '0;
            lo_hold_r <= '0;
        end else begin
            if (read_clear) begin
                upper_r <= up_cond;
                lower_r <= lo_cond;
                up_hold_r <= up_cond;
                lo_hold_r <= lo_cond;
            end else begin
                upper_r <= upper_r | up_cond | up_hold_r;
                lower_r <= lower_r | lo_cond | lo_hold_r;
                if (end_p) begin
                    up_hold_r <= '0;
                    lo_hold_r <= '0;
                end
            end
        end
    end

    // ==========================================================
    // Response code and outputs
    // ==========================================================
    // Injection outranks the invalid marking.
    always_comb begin
        if (inj_r) begin
            code_nxt = RT_SELF_TEST;
        end else if (force_invalid) begin
            code_nxt = RT_INVALID;
        end else begin
            code_nxt = RT_VALID;
        end
    end

    // Outputs are registered copies, refreshed every cycle rather than once per exchange.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_upper <= FAULT_RESET;
            fault_lower <= FAULT_RESET;
            fault_pair <= '0;
            data_resp_flags <= FAULT_RESET;
            response_type_code <= RT_VALID;
        end else begin
            fault_upper <= {4'h0, upper_r[3:0]};
            fault_lower <= {lower_r[7:1], 1'b0};
            fault_pair <= {4'h0, upper_r[3:0], lower_r[7:1], 1'b0};
            data_resp_flags <= {lower_r[7:3], lower_r[LO_SELF_BIT] | upper_r[UP_SWING_BIT], lower_r[1], 1'b0};
            response_type_code <= code_nxt;
        end
    end

endmodule

/* File: tb/fault_monitor_props.sv */
// Concurrent checks on the fault monitor's outputs against its raw conditions.
// Assumes it is bound to fault_monitor and sees only that module's ports.
module fault_monitor_props
    import fault_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fault_pkg::fault_cond_type cond,
    input wire logic [7:0] fault_upper,
    input wire logic [7:0] fault_lower,
    input wire logic [15:0] fault_pair,
    input wire logic [7:0] data_resp_flags,
    input wire fault_pkg::response_type_code_type response_type_code,
    input wire logic self_test_drive
);
    // ==========================================================
    // Shared sequence
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Six cycles cover the two-flop sync and both register stages; injection is left out.
    sequence held_s(c);
        (c && !self_test_drive) [*6];
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    chk_pair_joins: assert property (fault_pair == {fault_upper, fault_lower})
        else $error("pair differs from the two registers");
    chk_resp_merge: assert property (data_resp_flags == {fault_lower[7:3], fault_lower[2] | fault_upper[2],
        fault_lower[1:0]}) else $error("response flags wrong");
    chk_supply_follows: assert property ((fault_upper[1] | fault_upper[0]) |-> fault_lower[3])
        else $error("supply flag missing");
    chk_over_sets: assert property (held_s(cond.regulator_high) |-> fault_upper[1] && fault_lower[3])
        else $error("high flag missing");
    chk_under_sets: assert property (held_s(cond.regulator_low) |-> fault_upper[0] && fault_lower[3])
        else $error("low flag missing");
    chk_quad_sets: assert property (held_s(cond.quadrature_level > QUAD_LIMIT || cond.quad_accum_full)
        |-> fault_lower[6]) else $error("quadrature flag missing");
    chk_self_warn: assert property (held_s(cond.self_test_dev > SELF_WARN_LIMIT) |-> fault_lower[2])
        else $error("self test flag missing");
    // The self-test code outranks both markings while injection is requested.
    chk_invalid_code: assert property (held_s(cond.lock_lost || cond.self_test_dev > SELF_FAIL_LIMIT)
        ##0 (response_type_code != RT_SELF_TEST) |-> response_type_code == RT_INVALID)
        else $error("code not invalid");
    // A sticky lock flag keeps the invalid code until it is read.
    chk_quiet_valid: assert property (held_s(!cond.lock_lost && !fault_lower[7]
        && cond.self_test_dev <= SELF_FAIL_LIMIT) ##0 (response_type_code != RT_SELF_TEST)
        |-> response_type_code == RT_VALID) else $error("code not valid");
    chk_fail_marks: assert property (response_type_code == RT_INVALID |-> ##[0:2] fault_upper[3])
        else $error("fail flag missing");
    chk_code_legal: assert property (response_type_code != RT_READ_WRITE)
        else $error("read write code from monitor");
endmodule

bind fault_monitor fault_monitor_props i_props (
    .sys_clk(sys_clk),
    .rst(rst),
    .cond(cond),
    .fault_upper(fault_upper),
    .fault_lower(fault_lower),
    .fault_pair(fault_pair),
    .data_resp_flags(data_resp_flags),
    .response_type_code(response_type_code),
    .self_test_drive(self_test_drive)
);

/* File: tb/host_model.sv */
// Behavioural frame source standing in for the link's command decoder.
// Assumes the bench calls frame() from one process, one frame at a time.
module host_model
    import fault_pkg::*;
(
    output logic link_clk,
    output fault_pkg::frame_evt_type evt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic run = 1'b0;

    // ==========================================================
    // Link clock
    // ==========================================================
    // The clock only runs inside frames and rests low between them.
    initial begin
        link_clk = 1'b0;
        evt = '0;
        #3;
        forever begin
            #6;
            link_clk = run ? ~link_clk : 1'b0;
        end
    end

    // ==========================================================
    // Frame
    // ==========================================================
    // The injection bit keeps the last command's value, as the decoder latches it.
    task automatic frame(input logic rd, input logic inj);
        run = 1'b1;
        repeat (2) @(posedge link_clk);
        evt.inj_request <= inj;
        evt.frame_start <= 1'b1;
        @(posedge link_clk);
        evt.frame_start <= 1'b0;
        repeat (8) @(posedge link_clk);
        evt.fault_read <= rd;
        evt.frame_end <= 1'b1;
        @(posedge link_clk);
        evt.frame_end <= 1'b0;
        evt.fault_read <= 1'b0;
        repeat (6) @(posedge link_clk);
        run = 1'b0;
    endtask
endmodule

/* File: tb/sensor_fault_flag_monitor_tb.sv */
// Self-checking bench for the fault monitor with a frame source on the link side.
// Assumes the checker is bound in and the host model supplies link clock and events.
module sensor_fault_flag_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fault_pkg::*;
    localparam int SETTLE = 50;
    typedef struct {
        logic [4:0] b;
        logic [15:0] d;
        logic [15:0] q;
        logic [7:0] up;
        logic [7:0] lo;
        logic [7:0] rsp;
        response_type_code_type code;
    } row_type;
    // Bits of b: high, low, swing, lock, accumulator.
    row_type rows[11] = '{
        '{5'h10, 16'h0, 16'h0, 8'h02, 8'h08, 8'h08, RT_VALID},
        '{5'h08, 16'h0, 16'h0, 8'h01, 8'h08, 8'h08, RT_VALID},
        '{5'h04, 16'h0, 16'h0, 8'h04, 8'h00, 8'h04, RT_VALID},
        '{5'h02, 16'h0, 16'h0, 8'h08, 8'h80, 8'h80, RT_INVALID},
        '{5'h01, 16'h0, 16'h0, 8'h00, 8'h40, 8'h40, RT_VALID},
        '{5'h00, 16'h0, 16'h1001, 8'h00, 8'h40, 8'h40, RT_VALID},
        '{5'h00, 16'h0, 16'h1000, 8'h00, 8'h00, 8'h00, RT_VALID},
        '{5'h00, 16'h0201, 16'h0, 8'h00, 8'h04, 8'h04, RT_VALID},
        '{5'h00, 16'h0200, 16'h0, 8'h00, 8'h00, 8'h00, RT_VALID},
        '{5'h00, 16'h0741, 16'h0, 8'h08, 8'h04, 8'h04, RT_INVALID},
        '{5'h00, 16'h0740, 16'h0, 8'h00, 8'h04, 8'h04, RT_VALID}};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic link_clk;
    fault_cond_type cond = '0;
    frame_evt_type evt;
    logic nvm_wr_en = 1'b0;
    logic [3:0] nvm_wr_addr = 4'h0;
    logic [7:0] nvm_wr_data = 8'h00;
    logic vol_upset = 1'b0;
    logic [7:0] fault_upper;
    logic [7:0] fault_lower;
    logic [15:0] fault_pair;
    logic [7:0] data_resp_flags;
    response_type_code_type response_type_code;
    logic self_test_drive;
    int err_total = 0;
    int check_count = 0;
    int n;

    // ==========================================================
    // Instances and clock
    // ==========================================================
    fault_monitor #(.SETTLE_CYC(SETTLE)) i_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .link_clk(link_clk),
        .link_rst(rst),
        .cond(cond),
        .evt(evt),
        .nvm_wr_en(nvm_wr_en),
        .nvm_wr_addr(nvm_wr_addr),
        .nvm_wr_data(nvm_wr_data),
        .vol_upset(vol_upset),
        .fault_upper(fault_upper),
        .fault_lower(fault_lower),
        .fault_pair(fault_pair),
        .data_resp_flags(data_resp_flags),
        .response_type_code(response_type_code),
        .self_test_drive(self_test_drive)
    );
    host_model i_host (
        .link_clk(link_clk),
        .evt(evt)
    );
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic expect_flags(input logic [7:0] up, input logic [7:0] lo, input logic [7:0] rsp);
        check({24'h0, fault_upper}, {24'h0, up}, "upper");
        check({24'h0, fault_lower}, {24'h0, lo}, "lower");
        check({24'h0, data_resp_flags}, {24'h0, rsp}, "resp flags");
        check({16'h0, fault_pair}, {16'h0, up, lo}, "pair");
    endtask
    task automatic check_code(input response_type_code_type c);
        check({30'h0, response_type_code}, {30'h0, c}, "code");
    endtask
    // Reads settle eight cycles so the cleared flags reach the outputs.
    task automatic read_faults(input logic inj);
        i_host.frame(1'b1, inj);
        tick(8);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        // The checked memory has no reset, so it is filled while reset holds.
        nvm_wr_en = 1'b1;
        for (n = 0; n < 16; n++) begin
            nvm_wr_addr = n[3:0];
            tick(1);
        end
        nvm_wr_en = 1'b0;
        rst = 1'b0;
        tick(4);
        expect_flags(8'h00, 8'h00, 8'h00);
        check_code(RT_VALID);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        #1ms;
        err_total++;
        end_of_test();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            cond = {rows[i].b, rows[i].d, rows[i].q};
            tick(8);
            expect_flags(rows[i].up, rows[i].lo, rows[i].rsp);
            check_code(rows[i].code);
            read_faults(1'b0);
            expect_flags(rows[i].up, rows[i].lo, rows[i].rsp);
            cond = '0;
            tick(8);
            expect_flags(rows[i].up, rows[i].lo, rows[i].rsp);
            read_faults(1'b0);
            expect_flags(8'h00, 8'h00, 8'h00);
        end
        // A corrupted stored byte is caught by the next checksum round.
        nvm_wr_addr = 4'h3;
        nvm_wr_data = 8'h01;
        nvm_wr_en = 1'b1;
        tick(1);
        nvm_wr_en = 1'b0;
        for (n = 0; n < 2600 && fault_lower[LO_NVM_BIT] !== 1'b1; n++) tick(1);
        check({31'h0, fault_lower[LO_NVM_BIT]}, 32'h1, "checksum flag");
        nvm_wr_data = 8'h00;
        nvm_wr_en = 1'b1;
        tick(1);
        nvm_wr_en = 1'b0;
        tick(2600);
        read_faults(1'b0);
        expect_flags(8'h00, 8'h00, 8'h00);
        // An upset volatile copy stays wrong until reset reloads it.
        vol_upset = 1'b1;
        tick(1);
        vol_upset = 1'b0;
        for (n = 0; n < 60 && fault_lower[LO_VOL_BIT] !== 1'b1; n++) tick(1);
        check({31'h0, fault_lower[LO_VOL_BIT]}, 32'h1, "volatile flag");
        read_faults(1'b0);
        check({31'h0, fault_lower[LO_VOL_BIT]}, 32'h1, "volatile kept");
        do_reset();
        // Injection sets every flag and holds the self-test code while requested.
        i_host.frame(1'b0, 1'b1);
        for (n = 0; n < 60 && response_type_code !== RT_SELF_TEST; n++) tick(1);
        check_code(RT_SELF_TEST);
        tick(4);
        expect_flags(8'h0f, 8'hfe, 8'hfe);
        check({31'h0, self_test_drive}, 32'h1, "self test drive");
        read_faults(1'b1);
        check_code(RT_SELF_TEST);
        i_host.frame(1'b0, 1'b0);
        for (n = 0; n < SETTLE + 60 && self_test_drive !== 1'b0; n++) tick(1);
        check({31'h0, self_test_drive}, 32'h0, "decay end");
        tick(8);
        read_faults(1'b0);
        read_faults(1'b0);
        expect_flags(8'h00, 8'h00, 8'h00);
        check_code(RT_VALID);
        end_of_test();
    end
endmodule
